/* include/fmra_pkg.sv */
// constants, opcodes and register map of the field masked register alu
//
// Contract
// [RL1] right shifts on one or two move field down a digit, zero top, clear carry
// [RL2] right shifts ignore decimal or hex mode and fast mode
// [RL3] clear two zeroes selected digits of two, keeps others, clears carry
// [RL4] clear three zeroes selected digits of three, keeps others, clears carry
// [RL5] copy loads selected digits of two from one, one unchanged, clears carry
// [RL6] swap exchanges selected digits of two and three at once, clears carry
// [RL7] negate writes zero minus three into three, carry from its borrow
// [RL8] negate gives ten's complement in decimal, sixteen's in hex
// [RL9] complement writes zero minus three minus one, carry from result
// [RL10] complement gives nine's complement in decimal, fifteen's in hex
// [RL11] add writes one plus three into three, top selected carry into carry
// [RL12] subtract writes one minus three into three, top borrow into carry
// [RL13] add and subtract decimal-corrected in decimal mode, plain hex otherwise
// [RL14] every instruction of the group completes in one machine cycle
// [RL15] moves, clears and swaps ignore decimal or hex mode and fast mode
// [RL16] word ending in binary 10 is this class, bits 4..2 select field
// [RL17] unselected digits keep values, carry ripples only across selected digits
package fmra_pkg;

  // ==========================================================
  // datapath geometry
  localparam int NUM_DIGITS = 14;
  localparam int DIGIT_W    = 4;
  localparam int REG_W      = NUM_DIGITS * DIGIT_W;
  localparam int INSTR_W    = 10;
  localparam int EXEC_CYCLES = 1;

  localparam logic [1:0] CLASS_TAG = 2'h2;

  // ==========================================================
  // operations, instruction bits 9..5
  typedef enum logic [4:0] {
    OP_CLEAR_TWO           = 5'h01,
    OP_CLEAR_THREE         = 5'h02,
    OP_COPY_ONE_TO_TWO     = 5'h04,
    OP_SWAP_REG_TWO_THREE  = 5'h07,
    OP_ADD_ONE_THREE       = 5'h10,
    OP_SUB_ONE_THREE       = 5'h12,
    OP_NEGATE_THREE        = 5'h14,
    OP_COMPLEMENT_THREE    = 5'h15,
    OP_SHIFT_RIGHT_REG_ONE = 5'h1C,
    OP_SHIFT_RIGHT_REG_TWO = 5'h1D
  } fmra_op_t;

  // ==========================================================
  // field select codes and fixed digit masks
  localparam logic [2:0] FS_PTR_DIGIT = 3'h0;
  localparam logic [2:0] FS_EXP_SIGN  = 3'h1;
  localparam logic [2:0] FS_EXP       = 3'h2;
  localparam logic [2:0] FS_ALL       = 3'h3;
  localparam logic [2:0] FS_UP_TO_PTR = 3'h4;
  localparam logic [2:0] FS_SIGN_MANT = 3'h5;
  localparam logic [2:0] FS_MANT      = 3'h6;
  localparam logic [2:0] FS_SIGN      = 3'h7;

  localparam logic [13:0] MASK_EXP_SIGN  = 14'h0004;
  localparam logic [13:0] MASK_EXP       = 14'h0007;
  localparam logic [13:0] MASK_ALL       = 14'h3FFF;
  localparam logic [13:0] MASK_SIGN_MANT = 14'h3FF8;
  localparam logic [13:0] MASK_MANT      = 14'h1FF8;
  localparam logic [13:0] MASK_SIGN      = 14'h2000;

  // ==========================================================
  // apb register map, byte addresses
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_ONE_LO   = 8'h08;
  localparam logic [7:0]  ADDR_ONE_HI   = 8'h0C;
  localparam logic [7:0]  ADDR_TWO_LO   = 8'h10;
  localparam logic [7:0]  ADDR_TWO_HI   = 8'h14;
  localparam logic [7:0]  ADDR_THREE_LO = 8'h18;
  localparam logic [7:0]  ADDR_THREE_HI = 8'h1C;

  localparam int CTRL_DECIMAL_BIT = 0;
  localparam int CTRL_FAST_BIT    = 1;
  localparam int STATUS_CARRY_BIT = 0;

  localparam logic        RST_DECIMAL = 1'b1;
  localparam logic        RST_FAST    = 1'b0;
  localparam logic        RST_CARRY   = 1'b0;
  localparam logic [55:0] RST_REG     = 56'h0;

endpackage : fmra_pkg

/* src/fmra_field_mask.sv */
// field select code to digit enable mask
`timescale 1ns/1ps
`default_nettype none

module fmra_field_mask (
  input  wire logic [2:0]  field_select_code,
  input  wire logic [3:0]  pointer,
  output logic      [13:0] digit_mask
);

  // ==========================================================
  // decode
  always_comb begin
    digit_mask = '0;
    case (field_select_code)
      fmra_pkg::FS_PTR_DIGIT: begin
        // pointer values past the top digit select nothing
        for (int i = 0; i < fmra_pkg::NUM_DIGITS; i++) begin
          digit_mask[i] = (pointer == 4'(i));
        end
      end
      fmra_pkg::FS_UP_TO_PTR: begin
        for (int i = 0; i < fmra_pkg::NUM_DIGITS; i++) begin
          digit_mask[i] = (4'(i) <= pointer);
        end
      end
      fmra_pkg::FS_EXP_SIGN:  digit_mask = fmra_pkg::MASK_EXP_SIGN;
      fmra_pkg::FS_EXP:       digit_mask = fmra_pkg::MASK_EXP;
      fmra_pkg::FS_ALL:       digit_mask = fmra_pkg::MASK_ALL;
      fmra_pkg::FS_SIGN_MANT: digit_mask = fmra_pkg::MASK_SIGN_MANT;
      fmra_pkg::FS_MANT:      digit_mask = fmra_pkg::MASK_MANT;
      fmra_pkg::FS_SIGN:      digit_mask = fmra_pkg::MASK_SIGN;
      default:                digit_mask = '0;
    endcase
  end

endmodule : fmra_field_mask
`default_nettype wire

/* src/fmra_digit_alu.sv */
// digit serial add or subtract over a masked field, decimal or hex
`timescale 1ns/1ps
`default_nettype none

module fmra_digit_alu (
  input  wire logic [55:0] op_a,
  input  wire logic [55:0] op_b,
  input  wire logic [13:0] digit_mask,
  input  wire logic        subtract,
  input  wire logic        decimal,
  input  wire logic        carry_in,
  output logic      [55:0] result,
  output logic             carry_out
);

  logic [4:0] da;
  logic [4:0] db;
  logic [4:0] t;
  logic       c;

  // ==========================================================
  // ripple over digits; an unselected digit passes the carry unchanged
  always_comb begin
    c      = carry_in;
    result = op_a;
    da     = '0;
    db     = '0;
    t      = '0;
    for (int i = 0; i < fmra_pkg::NUM_DIGITS; i++) begin
      if (digit_mask[i]) begin // RL17
        da = {1'b0, op_a[i*4 +: 4]};
        db = {1'b0, op_b[i*4 +: 4]};
        if (!subtract) begin
          t = da + db + {4'h0, c};
          if (decimal ? (t > 5'h09) : (t > 5'h0F)) begin // RL13
            t = decimal ? (t + 5'h06) : t;
            c = 1'b1;
          end else begin
            c = 1'b0;
          end
        end else begin
          t = da - db - {4'h0, c};
          if (t[4]) begin
            // minus six in four bits is plus ten: decimal wraparound
            t = decimal ? (t - 5'h06) : t; // RL13
            c = 1'b1;
          end else begin
            c = 1'b0;
          end
        end
        result[i*4 +: 4] = t[3:0];
      end
    end
    carry_out = c;
  end

endmodule : fmra_digit_alu
`default_nettype wire

/* src/fmra_top.sv */
// field masked register alu: three digit registers, carry flag, apb control
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module fmra_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction port from decoder
  input  wire logic [9:0]  instr_word,
  input  wire logic        instr_valid,
  input  wire logic [3:0]  pointer,
  // state towards the rest of the processor
  output logic      [55:0] reg_one_q,
  output logic      [55:0] reg_two_q,
  output logic      [55:0] reg_three_q,
  output logic             carry_flag_q,
  output logic             instr_done_q,
  output logic             decimal_mode_q,
  output logic             fast_mode_q
);

  // ==========================================================
  // helpers

  function automatic logic [55:0] expand_mask(input logic [13:0] m);
    logic [55:0] r;
    r = '0;
    for (int i = 0; i < fmra_pkg::NUM_DIGITS; i++) begin
      r[i*4 +: 4] = {4{m[i]}};
    end
    return r;
  endfunction : expand_mask

  // selected digits from nv, all others kept from ov
  function automatic logic [55:0] merge_field(input logic [55:0] ov,
                                              input logic [55:0] nv,
                                              input logic [13:0] m);
    logic [55:0] e;
    e = expand_mask(m);
    return (nv & e) | (ov & ~e); // RL17
  endfunction : merge_field

  // one digit down inside the field, zero into its top digit
  function automatic logic [55:0] shr_field(input logic [55:0] x,
                                            input logic [13:0] m);
    logic [55:0] r;
    r = x;
    for (int i = 0; i < fmra_pkg::NUM_DIGITS - 1; i++) begin
      if (m[i]) begin
        r[i*4 +: 4] = m[i+1] ? x[i*4+4 +: 4] : 4'h0; // RL1
      end
    end
    if (m[13]) begin
      r[55:52] = 4'h0; // RL1
    end
    return r;
  endfunction : shr_field

  function automatic logic [31:0] hi_word(input logic [55:0] x);
    return {8'h00, x[55:32]};
  endfunction : hi_word

  // ==========================================================
  // decode

  logic         is_class;
  fmra_pkg::fmra_op_t op;
  logic [2:0]   field_code;
  logic [13:0]  digit_mask;

  // ce acts at the registers only; decode is pure logic
  assign is_class   = instr_valid && (instr_word[1:0] == fmra_pkg::CLASS_TAG); // RL16
  assign op         = fmra_pkg::fmra_op_t'(instr_word[9:5]); // RL16
  assign field_code = instr_word[4:2]; // RL16

  // mask follows the word in the same cycle, no pipeline
  fmra_field_mask u_mask (
    .field_select_code (field_code),
    .pointer           (pointer),
    .digit_mask        (digit_mask)
  );

  // ==========================================================
  // arithmetic operand select

  logic [55:0] alu_a;
  logic        alu_sub;
  logic        alu_cin;
  logic [55:0] alu_res;
  logic        alu_cout;

  always_comb begin
    alu_a   = reg_one_q;
    alu_sub = 1'b0;
    alu_cin = 1'b0;
    case (op)
      fmra_pkg::OP_ADD_ONE_THREE: begin
        alu_a   = reg_one_q; // RL11
        alu_sub = 1'b0;
      end
      fmra_pkg::OP_SUB_ONE_THREE: begin
        alu_a   = reg_one_q; // RL12
        alu_sub = 1'b1;
      end
      fmra_pkg::OP_NEGATE_THREE: begin
        alu_a   = '0; // RL7
        alu_sub = 1'b1;
      end
      fmra_pkg::OP_COMPLEMENT_THREE: begin
        // the extra borrow in gives the minus one
        alu_a   = '0; // RL9
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      default: begin
        alu_a   = reg_one_q;
        alu_sub = 1'b0;
        alu_cin = 1'b0;
      end
    endcase
  end

  // decimal mode picks ten's / nine's, hex sixteen's / fifteen's
  fmra_digit_alu u_alu (
    .op_a       (alu_a),
    .op_b       (reg_three_q),
    .digit_mask (digit_mask),
    .subtract   (alu_sub),
    .decimal    (decimal_mode_q), // RL8 RL10 RL13
    .carry_in   (alu_cin),
    .result     (alu_res),
    .carry_out  (alu_cout)
  );

  // ==========================================================
  // working registers and carry, one machine cycle per instruction

  logic [55:0] one_d;
  logic [55:0] two_d;
  logic [55:0] three_d;
  logic        carry_d;
  logic        done_d;

  // moves, clears and shifts never look at the mode bits
  always_comb begin
    one_d   = reg_one_q;
    two_d   = reg_two_q;
    three_d = reg_three_q;
    carry_d = carry_flag_q;
    done_d  = 1'b0;

    // preload of register one; an instruction wins
    if (psel && penable && pready && pwrite && pstrb[0]) begin
      case (paddr)
        fmra_pkg::ADDR_ONE_LO: one_d[31:0]  = pwdata;
        fmra_pkg::ADDR_ONE_HI: one_d[55:32] = pwdata[23:0];
        default: ;
      endcase
    end

    if (is_class) begin
      done_d = 1'b1; // RL14
      case (op)
        fmra_pkg::OP_SHIFT_RIGHT_REG_ONE: begin
          one_d   = shr_field(reg_one_q, digit_mask); // RL1 RL2
          carry_d = 1'b0; // RL1
        end
        fmra_pkg::OP_SHIFT_RIGHT_REG_TWO: begin
          two_d   = shr_field(reg_two_q, digit_mask); // RL1 RL2
          carry_d = 1'b0; // RL1
        end
        fmra_pkg::OP_CLEAR_TWO: begin
          two_d   = merge_field(reg_two_q, '0, digit_mask); // RL3 RL15
          carry_d = 1'b0; // RL3
        end
        fmra_pkg::OP_CLEAR_THREE: begin
          three_d = merge_field(reg_three_q, '0, digit_mask); // RL4 RL15
          carry_d = 1'b0; // RL4
        end
        fmra_pkg::OP_COPY_ONE_TO_TWO: begin
          two_d   = merge_field(reg_two_q, reg_one_q, digit_mask); // RL5 RL15
          carry_d = 1'b0; // RL5
        end
        fmra_pkg::OP_SWAP_REG_TWO_THREE: begin
          two_d   = merge_field(reg_two_q, reg_three_q, digit_mask); // RL6 RL15
          three_d = merge_field(reg_three_q, reg_two_q, digit_mask); // RL6
          carry_d = 1'b0; // RL6
        end
        fmra_pkg::OP_ADD_ONE_THREE,
        fmra_pkg::OP_SUB_ONE_THREE,
        fmra_pkg::OP_NEGATE_THREE,
        fmra_pkg::OP_COMPLEMENT_THREE: begin
          three_d = merge_field(reg_three_q, alu_res, digit_mask); // RL7 RL9 RL11 RL12
          carry_d = alu_cout; // RL7 RL9 RL11 RL12
        end
        default: begin
          // other words of the class belong to other blocks
          done_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_one_q    <= fmra_pkg::RST_REG;
      reg_two_q    <= fmra_pkg::RST_REG;
      reg_three_q  <= fmra_pkg::RST_REG;
      carry_flag_q <= fmra_pkg::RST_CARRY;
      instr_done_q <= 1'b0;
    end else if (ce) begin
      // ce low holds all state, the bus handshake too
      reg_one_q    <= one_d;
      reg_two_q    <= two_d;
      reg_three_q  <= three_d;
      carry_flag_q <= carry_d;
      instr_done_q <= done_d;
    end
  end

  // ==========================================================
  // apb slave: one wait state, read data registered with pready

  logic        acc_first;
  logic        acc_last;
  logic        addr_ok;
  logic [31:0] rd_word;
  logic        pready_d;
  logic [31:0] prdata_d;
  logic        pslverr_d;
  logic        dec_d;
  logic        fast_d;

  // the registered pready doubles as the wait flag
  assign acc_first = psel && penable && !pready;
  assign acc_last  = psel && penable && pready;

  always_comb begin
    addr_ok = 1'b1;
    rd_word = '0;
    case (paddr)
      fmra_pkg::ADDR_CTRL: begin
        rd_word[fmra_pkg::CTRL_DECIMAL_BIT] = decimal_mode_q;
        rd_word[fmra_pkg::CTRL_FAST_BIT]    = fast_mode_q;
      end
      fmra_pkg::ADDR_STATUS: rd_word[fmra_pkg::STATUS_CARRY_BIT] = carry_flag_q;
      fmra_pkg::ADDR_ONE_LO:   rd_word = reg_one_q[31:0];
      fmra_pkg::ADDR_ONE_HI:   rd_word = hi_word(reg_one_q);
      fmra_pkg::ADDR_TWO_LO:   rd_word = reg_two_q[31:0];
      fmra_pkg::ADDR_TWO_HI:   rd_word = hi_word(reg_two_q);
      fmra_pkg::ADDR_THREE_LO: rd_word = reg_three_q[31:0];
      fmra_pkg::ADDR_THREE_HI: rd_word = hi_word(reg_three_q);
      default:                 addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    pready_d  = acc_first;
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    dec_d     = decimal_mode_q;
    fast_d    = fast_mode_q;
    if (acc_first) begin
      prdata_d  = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_d = !addr_ok;
    end
    // write lands on the edge that samples pready high
    if (acc_last && pwrite && (paddr == fmra_pkg::ADDR_CTRL) && pstrb[0]) begin
      dec_d  = pwdata[fmra_pkg::CTRL_DECIMAL_BIT];
      fast_d = pwdata[fmra_pkg::CTRL_FAST_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready         <= 1'b0;
      prdata         <= '0;
      pslverr        <= 1'b0;
      decimal_mode_q <= fmra_pkg::RST_DECIMAL;
      fast_mode_q    <= fmra_pkg::RST_FAST;
    end else if (ce) begin
      pready         <= pready_d;
      prdata         <= prdata_d;
      pslverr        <= pslverr_d;
      decimal_mode_q <= dec_d;
      fast_mode_q    <= fast_d;
    end
  end

endmodule : fmra_top
`default_nettype wire

/* tb/fmra_checker_props.sv */
// concurrent checks on the instruction port of the field masked register alu
`timescale 1ns/1ps
`default_nettype none

module fmra_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [9:0]  instr_word,
  input wire logic        instr_valid,
  input wire logic [55:0] reg_one_q,
  input wire logic [55:0] reg_two_q,
  input wire logic [55:0] reg_three_q,
  input wire logic        carry_flag_q,
  input wire logic        instr_done_q
);
  // ==========================================================
  // decode of the offered word
  wire logic       take  = ce && instr_valid && instr_word[1:0] == 2'h2;
  wire logic [4:0] op    = instr_word[9:5];
  wire logic       all_f = instr_word[4:2] == 3'h3;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // properties
  property p_tag; ce && instr_valid && instr_word[1:0] != 2'h2 |=> !instr_done_q; endproperty
  a_tag: assert property (p_tag) else $error("done pulse for a foreign word");
  property p_done; take && op inside {5'h01, 5'h02, 5'h04, 5'h07, 5'h10, 5'h12, 5'h14,
    5'h15, 5'h1C, 5'h1D} |=> instr_done_q; endproperty
  a_done: assert property (p_done) else $error("op not done in one cycle");
  property p_shift; take && op inside {5'h1C, 5'h1D} |=> !carry_flag_q; endproperty
  a_shift: assert property (p_shift) else $error("shift left carry set");
  property p_move; take && op inside {5'h01, 5'h02, 5'h04, 5'h07} |=> !carry_flag_q; endproperty
  a_move: assert property (p_move) else $error("move left carry set");
  property p_copy; take && op == 5'h04 && all_f |=>
    reg_two_q == $past(reg_one_q) && $stable(reg_one_q); endproperty
  a_copy: assert property (p_copy) else $error("copy result wrong");
  property p_swap; take && op == 5'h07 && all_f |=>
    reg_two_q == $past(reg_three_q) && reg_three_q == $past(reg_two_q); endproperty
  a_swap: assert property (p_swap) else $error("swap result wrong");
  property p_clr; take && op == 5'h02 && all_f |=> reg_three_q == 56'h0 && $stable(reg_two_q);
  endproperty
  a_clr: assert property (p_clr) else $error("clear three result wrong");
  property p_neg; take && op == 5'h14 && all_f && reg_three_q == 56'h0 |=>
    reg_three_q == 56'h0 && !carry_flag_q; endproperty
  a_neg: assert property (p_neg) else $error("negate of zero wrong");
  property p_comp; take && op == 5'h15 && all_f |=> carry_flag_q; endproperty
  a_comp: assert property (p_comp) else $error("complement carry clear");
  property p_idle; !instr_valid |=> $stable(reg_three_q) && $stable(reg_two_q) && !instr_done_q;
  endproperty
  a_idle: assert property (p_idle) else $error("state moved while idle");

  c_add: cover property (take && op == 5'h10);
  c_neg: cover property (take && op == 5'h14 && !all_f);
  c_err: cover property (pready && pslverr);
endmodule : fmra_checker

bind fmra_top fmra_checker fmra_checker_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .pready(pready), .pslverr(pslverr),
  .instr_word(instr_word), .instr_valid(instr_valid), .reg_one_q(reg_one_q),
  .reg_two_q(reg_two_q), .reg_three_q(reg_three_q), .carry_flag_q(carry_flag_q),
  .instr_done_q(instr_done_q)
);
`default_nettype wire

/* tb/fmra_seq_model.sv */
// decoder and sequencer model feeding the instruction port
`timescale 1ns/1ps
`default_nettype none

module fmra_seq_model (
  input  wire logic       pclk,
  output logic      [9:0] instr_word,
  output logic            instr_valid,
  output logic      [3:0] pointer
);
  // ==========================================================
  // instruction issue
  initial begin
    instr_word  = 10'h155;
    instr_valid = 1'b0;
    pointer     = 4'hA;
  end

  // one word per call, entered right after a rising edge
  task automatic drive(input logic [9:0] w, input logic [3:0] p);
    instr_word  <= w;
    instr_valid <= 1'b1;
    pointer     <= p;
    @(posedge pclk);
  endtask : drive

  // idle word changes so a stale one never passes for a new one
  task automatic stop();
    instr_valid <= 1'b0;
    instr_word  <= ~instr_word;
    pointer     <= ~pointer;
  endtask : stop
endmodule : fmra_seq_model
`default_nettype wire

/* tb/fmra_test.sv */
// self-checking bench for the field masked register alu
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end

module fmra_test;
  // ==========================================================
  // signals and expected state
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, instr_valid, ec = 1'b0, edone = 1'b0, dec = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF, pointer;
  logic [9:0]  instr_word;
  logic [55:0] reg_one_q, reg_two_q, reg_three_q, e1 = 56'h0, e2 = 56'h0, e3 = 56'h0;
  logic        carry_flag_q, instr_done_q, decimal_mode_q, fast_mode_q;
  int          errors = 0;
  int          cmp_count = 0;

  always #2.5 pclk = ~pclk;

  fmra_top fmra_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_word(instr_word), .instr_valid(instr_valid),
    .pointer(pointer), .reg_one_q(reg_one_q), .reg_two_q(reg_two_q),
    .reg_three_q(reg_three_q), .carry_flag_q(carry_flag_q), .instr_done_q(instr_done_q),
    .decimal_mode_q(decimal_mode_q), .fast_mode_q(fast_mode_q));

  fmra_seq_model fmra_seq_model_inst (.pclk(pclk), .instr_word(instr_word),
    .instr_valid(instr_valid), .pointer(pointer));

  // ==========================================================
  // reference arithmetic
  function automatic logic [13:0] fmask(input logic [2:0] f, input logic [3:0] p);
    case (f)
      3'h0: return 14'h0001 << p;
      3'h1: return 14'h0004;
      3'h2: return 14'h0007;
      3'h3: return 14'h3FFF;
      3'h4: return p > 4'hD ? 14'h3FFF : 14'h3FFF >> (4'hD - p);
      3'h5: return 14'h3FF8;
      3'h6: return 14'h1FF8;
      default: return 14'h2000;
    endcase
  endfunction : fmask

  function automatic logic [55:0] dm(input logic [13:0] m);
    for (int i = 0; i < 14; i++) dm[4*i+:4] = {4{m[i]}};
  endfunction : dm

  function automatic logic [55:0] shr(input logic [55:0] v, input logic [13:0] m);
    logic [55:0] r;
    logic [14:0] mm;
    r = v;
    mm = {1'b0, m};
    for (int i = 0; i < 14; i++) if (m[i]) r[4*i+:4] = mm[i+1] ? v[4*i+4+:4] : 4'h0;
    return r;
  endfunction : shr

  // carry passes untouched over unselected digits
  function automatic logic [56:0] arith(input logic [55:0] a, b, input logic [13:0] m,
                                        input logic s, c);
    logic [55:0] r;
    int          t;
    int          bs;
    r = b;
    bs = dec ? 10 : 16;
    for (int i = 0; i < 14; i++) if (m[i]) begin
      t = s ? int'(a[4*i+:4]) - int'(b[4*i+:4]) - int'(c)
            : int'(a[4*i+:4]) + int'(b[4*i+:4]) + int'(c);
      c = t < 0 || t >= bs;
      t = t < 0 ? t + bs : (t >= bs ? t - bs : t);
      r[4*i+:4] = t[3:0];
    end
    return {c, r};
  endfunction : arith

  task automatic model(input logic [9:0] w, input logic [3:0] p);
    logic [13:0] m;
    logic [55:0] k;
    m = fmask(w[4:2], p);
    k = dm(m);
    edone = w[1:0] == 2'h2;
    if (edone) case (w[9:5])
      5'h01: e2 = e2 & ~k;
      5'h02: e3 = e3 & ~k;
      5'h04: e2 = (e2 & ~k) | (e1 & k);
      5'h07: {e2, e3} = {(e2 & ~k) | (e3 & k), (e3 & ~k) | (e2 & k)};
      5'h10: {ec, e3} = arith(e1, e3, m, 1'b0, 1'b0);
      5'h12: {ec, e3} = arith(e1, e3, m, 1'b1, 1'b0);
      5'h14: {ec, e3} = arith(56'h0, e3, m, 1'b1, 1'b0);
      5'h15: {ec, e3} = arith(56'h0, e3, m, 1'b1, 1'b1);
      5'h1C: e1 = shr(e1, m);
      5'h1D: e2 = shr(e2, m);
      default: edone = 1'b0;
    endcase
    if (edone && !(w[9:5] inside {5'h10, 5'h12, 5'h14, 5'h15})) ec = 1'b0;
  endtask : model

  // ==========================================================
  // drivers and comparisons
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errors++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_state();
    `CHK("reg one", e1, reg_one_q)
    `CHK("reg two", e2, reg_two_q)
    `CHK("reg three", e3, reg_three_q)
    `CHK("carry", ec, carry_flag_q)
    `CHK("done", edone, instr_done_q)
  endtask : chk_state

  task automatic step(input logic [9:0] w, input logic [3:0] p);
    @(posedge pclk);
    fmra_seq_model_inst.drive(w, p);
    fmra_seq_model_inst.stop();
    model(w, p);
    #1;
    chk_state();
  endtask : step

  task automatic pair(input logic [9:0] w1, w2);
    @(posedge pclk);
    fmra_seq_model_inst.drive(w1, 4'h3);
    fmra_seq_model_inst.drive(w2, 4'h3);
    fmra_seq_model_inst.stop();
    model(w1, 4'h3);
    model(w2, 4'h3);
    #1;
    chk_state();
  endtask : pair

  // ==========================================================
  // scenarios
  task automatic t_apb();
    logic [31:0] q;
    logic        e;
    apb(1'b0, fmra_pkg::ADDR_CTRL, 32'h0, q, e);
    `CHK("ctrl reset", 32'h00000001, q)
    apb(1'b0, 8'h40, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    apb(1'b1, fmra_pkg::ADDR_STATUS, 32'hFFFFFFFF, q, e);
    `CHK("read-only error", 1'b0, e)
    apb(1'b0, fmra_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("status", 32'h0, q)
    apb(1'b1, fmra_pkg::ADDR_CTRL, 32'h00000002, q, e);
    #1;
    `CHK("decimal mode", 1'b0, decimal_mode_q)
    `CHK("fast mode", 1'b1, fast_mode_q)
    $display("apb test done");
  endtask : t_apb

  task automatic t_ops();
    logic [4:0]  ops [12] = '{5'h15, 5'h07, 5'h15, 5'h1D, 5'h10, 5'h12,
                              5'h14, 5'h02, 5'h15, 5'h04, 5'h01, 5'h1C};
    logic [31:0] q;
    logic        e;
    for (int md = 0; md < 4; md++) begin
      apb(1'b1, fmra_pkg::ADDR_CTRL, 32'(md), q, e);
      apb(1'b1, fmra_pkg::ADDR_ONE_LO, 32'h98765432, q, e);
      apb(1'b1, fmra_pkg::ADDR_ONE_HI, 32'h00012345, q, e);
      e1 = 56'h01234598765432;
      dec = md[0];
      step({5'h01, 3'h3, 2'h2}, 4'h0);
      step({5'h02, 3'h3, 2'h2}, 4'h0);
      for (int f = 0; f < 8; f++) foreach (ops[k]) step({ops[k], 3'(f), 2'h2}, 4'(9 + md));
    end
    $display("operation test done");
  endtask : t_ops

  task automatic t_b2b();
    logic [31:0] q;
    logic        e;
    apb(1'b1, fmra_pkg::ADDR_CTRL, 32'h0, q, e);
    dec = 1'b0;
    pair({5'h02, 3'h3, 2'h2}, {5'h14, 3'h3, 2'h2});
    pair({5'h15, 3'h5, 2'h2}, {5'h07, 3'h3, 2'h2});
    pair({5'h15, 3'h3, 2'h2}, {5'h14, 3'h6, 2'h2});
    apb(1'b0, fmra_pkg::ADDR_STATUS, 32'h0, q, e);
    `CHK("status carry", {31'h0, ec}, q)
    apb(1'b0, fmra_pkg::ADDR_THREE_LO, 32'h0, q, e);
    `CHK("three low", e3[31:0], q)
    apb(1'b0, fmra_pkg::ADDR_THREE_HI, 32'h0, q, e);
    `CHK("three high", {8'h00, e3[55:32]}, q)
    $display("back to back test done");
  endtask : t_b2b

  task automatic t_refuse();
    step({5'h15, 3'h3, 2'h2}, 4'h0);
    step({5'h00, 3'h3, 2'h2}, 4'h0);
    step({5'h15, 3'h3, 2'h0}, 4'h0);
    step({5'h1F, 3'h3, 2'h2}, 4'h0);
    $display("refusal test done");
  endtask : t_refuse

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_ops();
    t_b2b();
    t_refuse();
    conclude();
  end
endmodule : fmra_test
`default_nettype wire
